// *** include/asb_pkg.sv ***
// Constants, register map and field layout for the serial baud and modem control block
package asb_pkg;

  localparam int          ADDR_W        = 8;
  localparam logic [7:0]  OFS_CTLB0     = 8'h00;
  localparam logic [7:0]  OFS_CTLB1     = 8'h04;
  localparam logic [7:0]  OFS_MODEM     = 8'h08;
  localparam logic [7:0]  OFS_CH0_STATUS_REG     = 8'h0c;
  localparam logic [7:0]  OFS_STAT1     = 8'h10;

  // Control B field positions
  localparam int          CB_MPBT       = 7;
  localparam int          CB_MP         = 6;
  localparam int          CB_PS         = 5;
  localparam int          CB_PEO        = 4;
  localparam int          CB_DR         = 3;
  localparam logic [7:0]  CTLB_RESET    = 8'h07;
  localparam logic [2:0]  SRC_EXTERNAL  = 3'h7;

  // Modem control field positions
  localparam int          MC_RTS        = 0;
  localparam int          MC_FLOW_SEL   = 1;
  localparam int          MC_CK1_DIS    = 2;
  localparam logic [7:0]  MODEM_RESET   = 8'h01;

  // Status 0 / 1 field positions
  localparam int          ST_TX_EMPTY   = 0;
  localparam int          ST_RX_FULL    = 1;
  localparam int          ST_CARRIER    = 2;
  localparam int          ST_ERR_LSB    = 3;
  localparam int          ST_CTS        = 1;

  // Divider ratios
  localparam int          PRESCALE_LO   = 10;
  localparam int          PRESCALE_HI   = 30;
  localparam int          SAMPLE_LO     = 16;
  localparam int          SAMPLE_HI     = 64;
  localparam int          CNT_W         = 11;
  localparam logic [CNT_W-1:0] HALF_LO  = CNT_W'(PRESCALE_LO / 2);
  localparam logic [CNT_W-1:0] HALF_HI  = CNT_W'(PRESCALE_HI / 2);
  localparam logic [5:0]  SAMP_LAST_LO  = 6'(SAMPLE_LO - 1);
  localparam logic [5:0]  SAMP_LAST_HI  = 6'(SAMPLE_HI - 1);

  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  typedef struct packed {
    logic       mp_bit_tx;
    logic       mp_mode;
    logic       prescale_hi;
    logic       parity_odd;
    logic       div64;
    logic [2:0] src_sel;
  } asb_ctlb_t;

  typedef struct packed {
    logic       sample_tick;
    logic       bit_tick;
    logic       clk_level;
  } asb_rate_t;

endpackage

// *** rtl/asb_baud_gen.sv ***
// Per-channel baud generator: prescaler, source divider, sampling divider
`timescale 1ns/1ps
`default_nettype none
module asb_baud_gen
  import asb_pkg::*;
(
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       ce,
  // Configuration
  input  wire asb_ctlb_t  ctlb,
  // External clock pin level
  input  wire logic       ext_clk,
  // Rate outputs
  output var asb_rate_t   rate
);

  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [5:0]       samp_r, samp_nxt;
  logic             lvl_r, lvl_nxt;
  logic             ext_prev_r, ext_prev_nxt;
  asb_rate_t        rate_r, rate_nxt;
  logic [CNT_W-1:0] half;
  logic             internal;
  logic             samp_evt;

  always_comb
  begin
    internal     = (ctlb.src_sel != SRC_EXTERNAL);
    half         = (ctlb.prescale_hi ? HALF_HI : HALF_LO) << ctlb.src_sel;
    cnt_nxt      = cnt_r;
    lvl_nxt      = lvl_r;
    samp_nxt     = samp_r;
    ext_prev_nxt = ext_clk;
    samp_evt     = 1'b0;
    if (internal)
    begin
      // Toggling every half period gives phi/(prescale*source) on the pin
      if (cnt_r >= half - CNT_W'(1))
      begin
        cnt_nxt  = '0;
        lvl_nxt  = ~lvl_r;
        samp_evt = ~lvl_r;
      end
      else
        cnt_nxt = cnt_r + CNT_W'(1);
    end
    else
    begin
      cnt_nxt  = '0;
      samp_evt = ext_clk & ~ext_prev_r;
    end
    rate_nxt.sample_tick = samp_evt;
    rate_nxt.bit_tick    = 1'b0;
    if (samp_evt)
    begin
      if (samp_r >= (ctlb.div64 ? SAMP_LAST_HI : SAMP_LAST_LO))
      begin
        samp_nxt          = '0;
        rate_nxt.bit_tick = 1'b1;
      end
      else
        samp_nxt = samp_r + 6'(1);
    end
    rate_nxt.clk_level = lvl_nxt;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_r      <= '0;
      samp_r     <= '0;
      lvl_r      <= 1'b0;
      // Idle pin level is high, so no false edge follows reset
      ext_prev_r <= 1'b1;
      rate_r     <= '0;
    end
    else if (ce)
    begin
      cnt_r      <= cnt_nxt;
      samp_r     <= samp_nxt;
      lvl_r      <= lvl_nxt;
      ext_prev_r <= ext_prev_nxt;
      rate_r     <= rate_nxt;
    end
  end

  assign rate = rate_r;

endmodule // asb_baud_gen
`default_nettype wire

// *** rtl/asb_top.sv ***
// Two-channel baud generation, modem control and clock pin sharing with AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
module asb_top
  import asb_pkg::*;
(
  // Clock, reset, enable
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              ce,
  // AXI4-Lite write address and data
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Modem pins
  input  wire logic              ch0_clear_to_send_input,
  input  wire logic              carrier_detect_input,
  output logic                   send_request_output,
  input  wire logic              ch1_shared_input,
  output logic                   sync_serial_rx_pin,
  // Serial clock pins, oe_n low while driving
  input  wire logic              ch0_clock_pin_i,
  output logic                   ch0_clock_pin_o,
  output logic                   ch0_clock_pin_oe_n,
  input  wire logic              ch1_clock_pin_i,
  output logic                   ch1_clock_pin_o,
  output logic                   ch1_clock_pin_oe_n,
  // DMA controller side
  input  wire logic              dma0_io_mode,
  input  wire logic              dma_tend_n,
  output logic                   dma_req_n,
  // Raw flags from transmitter and receiver
  input  wire logic [1:0]        tx_reg_empty_raw,
  input  wire logic              rx_full_raw,
  input  wire logic [2:0]        rx_err_raw,
  input  wire logic              parity_enable_bit,
  // Gated flags and rate outputs
  output logic [1:0]             tx_empty_flag,
  output logic                   rx_full_flag,
  output logic [2:0]             rx_err_flag,
  output logic [1:0]             parity_odd,
  output logic [1:0]             parity_active,
  output logic [1:0]             sample_tick,
  output logic [1:0]             bit_tick
);

  // AXI channel state
  logic              awready_r, awready_nxt;
  logic              wready_r, wready_nxt;
  logic              aw_held_r, aw_held_nxt;
  logic              w_held_r, w_held_nxt;
  logic [ADDR_W-1:0] awaddr_r, awaddr_nxt;
  logic [7:0]        wdata_r, wdata_nxt;
  logic              wstrb0_r, wstrb0_nxt;
  logic              bvalid_r, bvalid_nxt;
  logic [1:0]        bresp_r, bresp_nxt;
  logic              arready_r, arready_nxt;
  logic              rvalid_r, rvalid_nxt;
  logic [1:0]        rresp_r, rresp_nxt;
  logic [31:0]       rdata_r, rdata_nxt;
  logic              do_write;
  logic              ch0_status_reg_read;

  // Register state
  asb_ctlb_t         ctlb_r [2];
  asb_ctlb_t         ctlb_nxt [2];
  logic [7:0]        modem_r, modem_nxt;
  logic              carrier_bit_r, carrier_bit_nxt;
  logic              rx_hold_r, rx_hold_nxt;

  // Pin and flag state
  logic [1:0]        cts_lvl;
  logic [1:0]        ck_o_r, ck_o_nxt;
  logic [1:0]        ck_oe_n_r, ck_oe_n_nxt;
  logic              rts_r, rts_nxt;
  logic              srx_r, srx_nxt;
  logic              dreq_n_r, dreq_n_nxt;
  logic [1:0]        txe_r, txe_nxt;
  logic              rxf_r, rxf_nxt;
  logic [2:0]        err_r, err_nxt;
  logic [1:0]        peo_r, peo_nxt;
  logic [1:0]        pact_r, pact_nxt;
  asb_rate_t         rate [2];
  logic [1:0]        ext_clk;

  assign ext_clk = {ch1_clock_pin_i, ch0_clock_pin_i};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_chan
      asb_baud_gen u_baud (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ce      (ce),
        .ctlb    (ctlb_r[gi]),
        .ext_clk (ext_clk[gi]),
        .rate    (rate[gi])
      );
      assign sample_tick[gi] = rate[gi].sample_tick;
      assign bit_tick[gi]    = rate[gi].bit_tick;
    end
  endgenerate

  // Channel 1 shared pin counts as clear-to-send only when routed so
  always_comb
  begin
    cts_lvl[0] = ch0_clear_to_send_input;
    cts_lvl[1] = modem_r[MC_FLOW_SEL] & ch1_shared_input;
  end

  // AXI4-Lite slave: address and data taken independently, response after both
  always_comb
  begin
    awready_nxt = awready_r;
    wready_nxt  = wready_r;
    aw_held_nxt = aw_held_r;
    w_held_nxt  = w_held_r;
    awaddr_nxt  = awaddr_r;
    wdata_nxt   = wdata_r;
    wstrb0_nxt  = wstrb0_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    arready_nxt = 1'b0;
    rvalid_nxt  = rvalid_r;
    rresp_nxt   = rresp_r;
    rdata_nxt   = rdata_r;
    do_write    = 1'b0;
    ch0_status_reg_read  = 1'b0;
    if (s_axi_awvalid && awready_r)
    begin
      awready_nxt = 1'b0;
      aw_held_nxt = 1'b1;
      awaddr_nxt  = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_r)
    begin
      wready_nxt = 1'b0;
      w_held_nxt = 1'b1;
      wdata_nxt  = s_axi_wdata[7:0];
      wstrb0_nxt = s_axi_wstrb[0];
    end
    if (aw_held_r && w_held_r && !bvalid_r)
    begin
      do_write    = wstrb0_r;
      aw_held_nxt = 1'b0;
      w_held_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      case (awaddr_r)
        OFS_CTLB0, OFS_CTLB1, OFS_MODEM, OFS_CH0_STATUS_REG, OFS_STAT1: bresp_nxt = RESP_OKAY;
        default: bresp_nxt = RESP_SLVERR;
      endcase
    end
    if (bvalid_r && s_axi_bready)
    begin
      bvalid_nxt  = 1'b0;
      awready_nxt = 1'b1;
      wready_nxt  = 1'b1;
    end
    if (!rvalid_r && !arready_r)
      arready_nxt = 1'b1;
    if (s_axi_arvalid && arready_r)
    begin
      arready_nxt = 1'b0;
      rvalid_nxt  = 1'b1;
      rresp_nxt   = RESP_OKAY;
      rdata_nxt   = '0;
      case (s_axi_araddr)
        OFS_CTLB0: rdata_nxt[7:0] = {ctlb_r[0][7:6], cts_lvl[0], ctlb_r[0][4:0]};
        OFS_CTLB1: rdata_nxt[7:0] = {ctlb_r[1][7:6], cts_lvl[1], ctlb_r[1][4:0]};
        OFS_MODEM: rdata_nxt[7:0] = modem_r;
        OFS_CH0_STATUS_REG:
        begin
          ch0_status_reg_read = 1'b1;
          rdata_nxt[ST_TX_EMPTY] = txe_r[0];
          rdata_nxt[ST_RX_FULL]  = rxf_r;
          rdata_nxt[ST_CARRIER]  = carrier_bit_r;
          rdata_nxt[ST_ERR_LSB +: 3] = err_r;
        end
        OFS_STAT1:
        begin
          rdata_nxt[ST_TX_EMPTY] = txe_r[1];
          rdata_nxt[ST_CTS]      = cts_lvl[1];
        end
        default: rresp_nxt = RESP_SLVERR;
      endcase
    end
    if (rvalid_r && s_axi_rready)
      rvalid_nxt = 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      awaddr_r  <= '0;
      wdata_r   <= '0;
      wstrb0_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rresp_r   <= RESP_OKAY;
      rdata_r   <= '0;
    end
    else if (ce)
    begin
      awready_r <= awready_nxt;
      wready_r  <= wready_nxt;
      aw_held_r <= aw_held_nxt;
      w_held_r  <= w_held_nxt;
      awaddr_r  <= awaddr_nxt;
      wdata_r   <= wdata_nxt;
      wstrb0_r  <= wstrb0_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r  <= rvalid_nxt;
      rresp_r   <= rresp_nxt;
      rdata_r   <= rdata_nxt;
    end
  end

  // Registers, carrier detect bit and receive hold
  always_comb
  begin
    ctlb_nxt[0]     = ctlb_r[0];
    ctlb_nxt[1]     = ctlb_r[1];
    modem_nxt       = modem_r;
    carrier_bit_nxt = carrier_bit_r;
    rx_hold_nxt     = rx_hold_r;
    if (do_write)
    begin
      case (awaddr_r)
        OFS_CTLB0: ctlb_nxt[0] = wdata_r;
        OFS_CTLB1: ctlb_nxt[1] = wdata_r;
        OFS_MODEM: modem_nxt   = {5'h0, wdata_r[2:0]};
        default: ;
      endcase
    end
    // A status read with the input already low releases; a high input wins over the read
    if (ch0_status_reg_read && !carrier_detect_input)
    begin
      carrier_bit_nxt = 1'b0;
      rx_hold_nxt     = 1'b0;
    end
    if (carrier_detect_input)
    begin
      carrier_bit_nxt = 1'b1;
      rx_hold_nxt     = 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctlb_r[0]     <= CTLB_RESET;
      ctlb_r[1]     <= CTLB_RESET;
      modem_r       <= MODEM_RESET;
      carrier_bit_r <= 1'b0;
      rx_hold_r     <= 1'b0;
    end
    else if (ce)
    begin
      ctlb_r[0]     <= ctlb_nxt[0];
      ctlb_r[1]     <= ctlb_nxt[1];
      modem_r       <= modem_nxt;
      carrier_bit_r <= carrier_bit_nxt;
      rx_hold_r     <= rx_hold_nxt;
    end
  end

  // Pin muxing and flag gating, all outputs registered
  always_comb
  begin
    rts_nxt  = modem_nxt[MC_RTS];
    srx_nxt  = modem_r[MC_FLOW_SEL] ? 1'b1 : ch1_shared_input;
    txe_nxt  = tx_reg_empty_raw & ~cts_lvl;
    rxf_nxt  = rx_full_raw & ~rx_hold_nxt;
    err_nxt  = rx_err_raw & {3{~rx_hold_nxt}};
    peo_nxt  = {ctlb_r[1].parity_odd, ctlb_r[0].parity_odd};
    // Parity on or off comes only from the separate enable
    pact_nxt = {2{parity_enable_bit}};
    // Channel 0 pin
    if (dma0_io_mode)
    begin
      ck_oe_n_nxt[0] = 1'b1;
      ck_o_nxt[0]    = 1'b0;
      dreq_n_nxt     = ch0_clock_pin_i;
    end
    else
    begin
      ck_oe_n_nxt[0] = (ctlb_r[0].src_sel == SRC_EXTERNAL);
      ck_o_nxt[0]    = rate[0].clk_level;
      dreq_n_nxt     = 1'b1;
    end
    // Channel 1 pin
    if (modem_r[MC_CK1_DIS])
    begin
      ck_oe_n_nxt[1] = 1'b0;
      ck_o_nxt[1]    = dma_tend_n;
    end
    else
    begin
      ck_oe_n_nxt[1] = (ctlb_r[1].src_sel == SRC_EXTERNAL);
      ck_o_nxt[1]    = rate[1].clk_level;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ck_oe_n_r <= 2'h3;
      ck_o_r    <= 2'h0;
      rts_r     <= 1'b1;
      srx_r     <= 1'b1;
      dreq_n_r  <= 1'b1;
      txe_r     <= 2'h0;
      rxf_r     <= 1'b0;
      err_r     <= 3'h0;
      peo_r     <= 2'h0;
      pact_r    <= 2'h0;
    end
    else if (ce)
    begin
      ck_oe_n_r <= ck_oe_n_nxt;
      ck_o_r    <= ck_o_nxt;
      rts_r     <= rts_nxt;
      srx_r     <= srx_nxt;
      dreq_n_r  <= dreq_n_nxt;
      txe_r     <= txe_nxt;
      rxf_r     <= rxf_nxt;
      err_r     <= err_nxt;
      peo_r     <= peo_nxt;
      pact_r    <= pact_nxt;
    end
  end

  assign s_axi_awready      = awready_r;
  assign s_axi_wready       = wready_r;
  assign s_axi_bvalid       = bvalid_r;
  assign s_axi_bresp        = bresp_r;
  assign s_axi_arready      = arready_r;
  assign s_axi_rvalid       = rvalid_r;
  assign s_axi_rresp        = rresp_r;
  assign s_axi_rdata        = rdata_r;
  assign send_request_output = rts_r;
  assign sync_serial_rx_pin = srx_r;
  assign ch0_clock_pin_o    = ck_o_r[0];
  assign ch1_clock_pin_o    = ck_o_r[1];
  assign ch0_clock_pin_oe_n = ck_oe_n_r[0];
  assign ch1_clock_pin_oe_n = ck_oe_n_r[1];
  assign dma_req_n          = dreq_n_r;
  assign tx_empty_flag      = txe_r;
  assign rx_full_flag       = rxf_r;
  assign rx_err_flag        = err_r;
  assign parity_odd         = peo_r;
  assign parity_active      = pact_r;

endmodule // asb_top
`default_nettype wire

// *** sim/asb_monitor.sv ***
// Port-level checks for the serial baud and modem control block
`timescale 1ns/1ps
`default_nettype none
module asb_monitor
(
  // Clock and reset
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       ce,
  // Inputs watched
  input wire logic       ch0_clear_to_send_input,
  input wire logic       carrier_detect_input,
  input wire logic       ch1_shared_input,
  input wire logic       parity_enable_bit,
  input wire logic       dma0_io_mode,
  input wire logic       ch0_clock_pin_i,
  input wire logic [1:0] tx_reg_empty_raw,
  // Outputs watched
  input wire logic [1:0] tx_empty_flag,
  input wire logic       rx_full_flag,
  input wire logic [2:0] rx_err_flag,
  input wire logic [1:0] parity_active,
  input wire logic [1:0] bit_tick,
  input wire logic [1:0] sample_tick,
  input wire logic       send_request_output,
  input wire logic       sync_serial_rx_pin,
  input wire logic       dma_req_n,
  input wire logic       ch0_clock_pin_oe_n,
  input wire logic       ch1_clock_pin_oe_n
);
  default clocking dc @(posedge aclk); endclocking
  default disable iff (!aresetn);

  cts_gate_a: assert property (ce |=> tx_empty_flag[0] ==
    ($past(tx_reg_empty_raw[0]) & ~$past(ch0_clear_to_send_input)))
    else $error("tx empty flag not gated by clear to send");
  tx1_gate_a: assert property (ce |=> !tx_empty_flag[1] || $past(tx_reg_empty_raw[1]))
    else $error("channel 1 tx empty set without raw flag");
  carrier_hold_a: assert property (ce && carrier_detect_input |=> !rx_full_flag && rx_err_flag == 3'h0)
    else $error("receive flags not held under carrier detect");
  reset_pins_a: assert property (disable iff (1'b0) !aresetn |=>
    ch0_clock_pin_oe_n && ch1_clock_pin_oe_n && send_request_output && dma_req_n)
    else $error("pin state wrong during reset");
  dma_pin_a: assert property (ce && dma0_io_mode |=>
    ch0_clock_pin_oe_n && dma_req_n == $past(ch0_clock_pin_i))
    else $error("channel 0 clock pin not handed to dma request");
  parity_sel_a: assert property (ce |=> parity_active == {2{$past(parity_enable_bit)}})
    else $error("parity enable not passed through");
  bit_space_a: assert property (bit_tick[0] |=> !bit_tick[0] [*8])
    else $error("bit ticks too close");
  rxs_route_a: assert property (ce |=> sync_serial_rx_pin || !$past(ch1_shared_input))
    else $error("sync receive pin low without input low");
  tick_pair_a: assert property ((bit_tick & ~sample_tick) == 2'h0)
    else $error("bit tick without sample tick");

  cover property (dma0_io_mode && !dma_req_n);
  cover property (carrier_detect_input ##1 !carrier_detect_input);
  cover property (bit_tick[0]);
endmodule // asb_monitor
`default_nettype wire

// *** sim/asb_peer_model.sv ***
// Far-side model: external serial clock source and clock pin resolution
`timescale 1ns/1ps
`default_nettype none
module asb_peer_model
#(
  parameter int HALF = 4
)
(
  // Clock and command
  input  wire logic aclk,
  input  wire logic ext_on,
  // Design side of the pins
  input  wire logic oe_n0,
  input  wire logic o0,
  input  wire logic oe_n1,
  input  wire logic o1,
  // Resolved pin levels
  output logic      pin0,
  output logic      pin1
);
  int   cnt = 0;
  logic clk_r = 1'b1;
  // Clock stands still high outside traffic, as the pull-up leaves an idle pin
  always @(posedge aclk)
  begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (!ext_on)
      clk_r <= 1'b1;
    else if (cnt == HALF - 1)
      clk_r <= ~clk_r;
  end
  assign pin0 = oe_n0 ? clk_r : o0;
  assign pin1 = oe_n1 ? 1'b1 : o1;
endmodule // asb_peer_model
`default_nettype wire

// *** sim/asb_top_test.sv ***
// Self-checking bench for the serial baud and modem control block
`timescale 1ns/1ps
`default_nettype none
module asb_top_test
  import asb_pkg::*;
;
  logic aclk, aresetn, ce, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0]       s_axi_wdata, s_axi_rdata, v;
  logic [3:0]        s_axi_wstrb;
  logic [2:0]        rx_err_raw, rx_err_flag;
  logic [1:0]        s_axi_bresp, s_axi_rresp, tx_reg_empty_raw, tx_empty_flag;
  logic [1:0]        parity_odd, parity_active, sample_tick, bit_tick;
  logic ch0_clear_to_send_input, carrier_detect_input, send_request_output, ch1_shared_input;
  logic sync_serial_rx_pin, ch0_clock_pin_i, ch0_clock_pin_o, ch0_clock_pin_oe_n, ch1_clock_pin_i;
  logic ch1_clock_pin_o, ch1_clock_pin_oe_n, dma0_io_mode, dma_tend_n, dma_req_n, rx_full_raw;
  logic rx_full_flag, parity_enable_bit, ext_on, prv;
  int   error_cnt = 0;
  int   n_checks = 0;
  int   mreg[3];
  int   e, p;

  asb_top DUT (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .ch0_clear_to_send_input, .carrier_detect_input, .send_request_output,
    .ch1_shared_input, .sync_serial_rx_pin, .ch0_clock_pin_i, .ch0_clock_pin_o,
    .ch0_clock_pin_oe_n, .ch1_clock_pin_i, .ch1_clock_pin_o, .ch1_clock_pin_oe_n, .dma0_io_mode,
    .dma_tend_n, .dma_req_n, .tx_reg_empty_raw, .rx_full_raw, .rx_err_raw, .parity_enable_bit,
    .tx_empty_flag, .rx_full_flag, .rx_err_flag, .parity_odd, .parity_active, .sample_tick,
    .bit_tick);
  asb_peer_model #(.HALF(4)) PEER (.aclk, .ext_on, .oe_n0(ch0_clock_pin_oe_n),
    .o0(ch0_clock_pin_o), .oe_n1(ch1_clock_pin_oe_n), .o1(ch1_clock_pin_o),
    .pin0(ch0_clock_pin_i), .pin1(ch1_clock_pin_i));

  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk) prv <= ch0_clock_pin_o;

  task end_of_test;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] s, input logic [31:0] x);
    n_checks++;
    if (s !== x)
    begin
      error_cnt++;
      $display("Error %s expected %0h seen %0h", n, x, s);
    end
  endtask
  task chb(input string n, input logic s, input logic x);
    chk(n, {31'h0, s}, {31'h0, x});
  endtask
  task st;
    repeat (2) @(posedge aclk);
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bresp", 32'(s_axi_bresp), 32'(er));
  endtask
  task rc(input logic [7:0] a, input logic [31:0] x, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk("rdata", s_axi_rdata, x);
    chk("rresp", 32'(s_axi_rresp), 32'(er));
  endtask
  // Control B read: bit 5 shows the live clear-to-send level, not the stored prescale
  function automatic int cb(input int ch);
    logic c;
    c = ch ? (mreg[2][1] & ch1_shared_input) : ch0_clear_to_send_input;
    return (mreg[ch] & 'hdf) | (int'(c) << 5);
  endfunction
  // Cycles between two pin rises (w=0) or bit ticks (w=1); first span may be partial
  task per(input logic w, input int x);
    int k, n;
    repeat (2)
    begin
      k = 0;
      n = 0;
      while (k < 2 && n < 9000)
      begin
        @(posedge aclk);
        if (k > 0)
          n++;
        if ((w ? bit_tick[0] : ch0_clock_pin_o & ~prv) === 1'b1)
          k++;
      end
    end
    chk("period", n, x);
  endtask

  initial
  begin
    #900us;
    error_cnt++;
    end_of_test;
  end

  initial
  begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awaddr,
      s_axi_araddr, s_axi_wdata, carrier_detect_input, dma0_io_mode, tx_reg_empty_raw,
      rx_full_raw, rx_err_raw, parity_enable_bit, ext_on, aresetn} = '0;
    {ce, ch0_clear_to_send_input, ch1_shared_input, dma_tend_n} = 4'hf;
    s_axi_wstrb = 4'hf;
    mreg = '{7, 7, 1};
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    void'($urandom(66));
    @(posedge aclk);
    chb("oe0", ch0_clock_pin_oe_n, 1'b1);
    chb("oe1", ch1_clock_pin_oe_n, 1'b1);
    rc(OFS_CTLB0, cb(0), RESP_OKAY);
    rc(OFS_CTLB1, cb(1), RESP_OKAY);
    rc(OFS_MODEM, 1, RESP_OKAY);
    $display("test reset done");
    for (int i = 0; i < 4; i++)
    begin
      v = $urandom;
      parity_enable_bit <= v[8];
      wr(OFS_CTLB0, v[7:0], RESP_OKAY);
      mreg[0] = v[7:0];
      rc(OFS_CTLB0, cb(0), RESP_OKAY);
      chb("odd", parity_odd[0], v[4]);
      wr(OFS_MODEM, {7'h0, v[9]}, RESP_OKAY);
      st;
      chb("rts", send_request_output, v[9]);
    end
    mreg[2] = v[9];
    $display("test registers done");
    for (int c = 0; c < 7; c++)
    begin
      p = $urandom_range(1);
      wr(OFS_CTLB0, 8'(p * 32 + c), RESP_OKAY);
      per(1'b0, (p ? PRESCALE_HI : PRESCALE_LO) << c);
      chb("oe0", ch0_clock_pin_oe_n, 1'b0);
    end
    for (int d = 0; d < 2; d++)
    begin
      wr(OFS_CTLB0, 8'(d * 8), RESP_OKAY);
      per(1'b1, PRESCALE_LO * (d ? 64 : 16));
    end
    $display("test rates done");
    wr(OFS_CTLB0, 8'h07, RESP_OKAY);
    mreg[0] = 7;
    ext_on <= 1'b1;
    per(1'b1, 2 * 4 * 16);
    chb("oe0", ch0_clock_pin_oe_n, 1'b1);
    ext_on <= 1'b0;
    $display("test external done");
    tx_reg_empty_raw <= 2'h3;
    ce <= 1'b0;
    st;
    chb("frozen", tx_empty_flag[1], 1'b0);
    ce <= 1'b1;
    st;
    chb("txe1", tx_empty_flag[1], 1'b1);
    chb("txe0", tx_empty_flag[0], 1'b0);
    e = $urandom_range(7);
    ch0_clear_to_send_input <= 1'b0;
    rx_err_raw <= 3'(e);
    rx_full_raw <= 1'b1;
    carrier_detect_input <= 1'b1;
    st;
    chb("txe0", tx_empty_flag[0], 1'b1);
    chb("rxf", rx_full_flag, 1'b0);
    carrier_detect_input <= 1'b0;
    st;
    chk("err", 32'(rx_err_flag), 0);
    rc(OFS_CH0_STATUS_REG, 32'h05, RESP_OKAY);
    st;
    chk("err", 32'(rx_err_flag), e);
    rc(OFS_CH0_STATUS_REG, e * 8 + 3, RESP_OKAY);
    wr(OFS_MODEM, 8'h02, RESP_OKAY);
    mreg[2] = 2;
    st;
    rc(OFS_STAT1, 32'h02, RESP_OKAY);
    rc(OFS_CTLB1, cb(1), RESP_OKAY);
    chb("rxs", sync_serial_rx_pin, 1'b1);
    chb("rts", send_request_output, 1'b0);
    ch1_shared_input <= 1'b0;
    wr(OFS_MODEM, 8'h00, RESP_OKAY);
    mreg[2] = 0;
    st;
    chb("rxs", sync_serial_rx_pin, 1'b0);
    rc(OFS_STAT1, 32'h01, RESP_OKAY);
    $display("test modem done");
    dma0_io_mode <= 1'b1;
    ext_on <= 1'b1;
    wr(OFS_CTLB0, 8'h00, RESP_OKAY);
    mreg[0] = 0;
    st;
    chb("oe0", ch0_clock_pin_oe_n, 1'b1);
    repeat (20) @(posedge aclk);
    dma0_io_mode <= 1'b0;
    ext_on <= 1'b0;
    dma_tend_n <= 1'b0;
    wr(OFS_MODEM, 8'h04, RESP_OKAY);
    mreg[2] = 4;
    st;
    chb("oe1", ch1_clock_pin_oe_n, 1'b0);
    chb("ck1", ch1_clock_pin_o, 1'b0);
    dma_tend_n <= 1'b1;
    st;
    chb("ck1", ch1_clock_pin_o, 1'b1);
    $display("test dma done");
    rc(8'h20, 0, RESP_SLVERR);
    wr(8'h20, 8'hff, RESP_SLVERR);
    s_axi_wstrb <= 4'h0;
    wr(OFS_CTLB0, 8'hff, RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    rc(OFS_CTLB0, cb(0), RESP_OKAY);
    $display("test unmapped done");
    end_of_test;
  end
endmodule // asb_top_test

bind asb_top asb_monitor MON (.aclk, .aresetn, .ce, .ch0_clear_to_send_input,
  .carrier_detect_input, .ch1_shared_input, .parity_enable_bit, .dma0_io_mode, .ch0_clock_pin_i,
  .tx_reg_empty_raw, .tx_empty_flag, .rx_full_flag, .rx_err_flag, .parity_active, .bit_tick,
  .send_request_output, .sync_serial_rx_pin, .dma_req_n, .ch0_clock_pin_oe_n, .sample_tick,
  .ch1_clock_pin_oe_n);
`default_nettype wire
